// [rtl/bms_sequencer.v]
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "bms_regs.vh"

module bms_sequencer #(
  parameter integer PERIOD_CYC  = 400,   // switching period at clk_i
  parameter integer HIC_OFF_CYC = 40000, // hiccup off period
  parameter integer CFG_CYC     = (`BMS_T_CFG_NS + `BMS_CLK_NS - 1) / `BMS_CLK_NS,
  parameter integer SHDN_CYC    = `BMS_T_SHDN_NS / `BMS_CLK_NS
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  input  wire        bias_ok_i,          // bias above 2.7 V
  input  wire        line_above_en_i,    // line above enable threshold
  input  wire        line_above_lock_i,  // line lockout comparator (50 mV hyst analog)
  input  wire        supply_ok_i,        // internal supply above lockout level
  input  wire        fb_above_ov_i,      // feedback above 110%
  input  wire        fb_above_ovclr_i,   // feedback above 105%
  input  wire        fb_above_uv_i,      // feedback above 90%
  input  wire        fb_above_uvclr_i,   // feedback above 95%
  input  wire        cur_limit_i,        // peak current limit tripped
  input  wire        pwm_off_i,          // loop asks switch off this cycle
  input  wire        over_temp_i,
  input  wire        sync_mode_i,        // external clock on line pin
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output wire        irq_o,
  output reg         hyst_src_en_o,
  output reg         ss_pulldown_o,
  output reg         switch_en_o,
  output reg         regulators_en_o,
  output reg         power_good_pd_o,
  output reg         overvoltage_o,
  output reg         cycle_start_o
);

  // ============================================================
  // derived counts
  localparam integer FILT_CYC = (`BMS_T_FILT_NS + `BMS_CLK_NS - 1) / `BMS_CLK_NS + 1;
  localparam integer ON_LO    = PERIOD_CYC * `BMS_DMAX_LO_PCT / `BMS_PCT_FULL;
  localparam integer ON_HI    = PERIOD_CYC * `BMS_DMAX_HI_PCT / `BMS_PCT_FULL;
  localparam [31:0]  ZERO32   = 32'h0;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] tmr;
  reg  [15:0] filt_cnt;
  reg  [31:0] pcnt;
  reg  [6:0]  lim_cnt;
  reg  [3:0]  clean_cnt;
  reg         lim_seen;
  reg         sync_d;
  reg  [1:0]  ctrl;
  reg  [`BMS_EV_W-1:0] irq_stat;
  reg  [`BMS_EV_W-1:0] irq_mask;
  reg         hic_trip;
  reg         pg_bad_d;
  reg         ov_d;
  reg         tsd_d;

  wire        band_ok   = bias_ok_i & line_above_en_i & ~line_above_lock_i;
  wire        enter_ok  = bias_ok_i & line_above_en_i;
  wire        filt_done = (filt_cnt >= FILT_CYC[15:0]);
  wire        tmr_cfg   = (tmr >= CFG_CYC[31:0]);
  wire        tmr_shdn  = (tmr >= SHDN_CYC[31:0]);
  wire        tmr_hic   = (tmr >= HIC_OFF_CYC[31:0]);
  wire [31:0] on_max    = ctrl[`BMS_CTRL_FHIGH] ? ON_LO[31:0] : ON_HI[31:0];
  // the switch output is registered, so the cut is issued one count early
  wire        forced_off = (pcnt >= on_max - 32'h1);
  wire        sync_fall = sync_mode_i & sync_d & ~line_above_lock_i;
  wire        period_end = (pcnt >= PERIOD_CYC[31:0] - 32'h1);
  wire        new_cycle = period_end | (sync_fall & ~forced_off);
  wire        running   = (state == `BMS_ST_RUN);
  wire        sw_allow  = running & supply_ok_i & ~over_temp_i;
  // in sync mode the lockout comparator toggles with the clock, so it does not end run
  wire        line_low  = ~line_above_lock_i & ~sync_mode_i;

  // ============================================================
  // mode sequencing
  always @* begin
    next_state = state;
    case (state)
      `BMS_ST_SHDN: if (filt_done) next_state = `BMS_ST_CFG;
      `BMS_ST_CFG:  if (tmr_cfg)   next_state = `BMS_ST_STBY;
      `BMS_ST_STBY: if (line_above_lock_i) next_state = `BMS_ST_RUN;
      `BMS_ST_RUN: begin
        if (hic_trip)
          next_state = `BMS_ST_HIC;
        else if (line_low)
          next_state = `BMS_ST_STBY;
      end
      `BMS_ST_HIC:  if (tmr_hic) next_state = `BMS_ST_STBY;
      default:      next_state = `BMS_ST_SHDN;
    endcase
    // line below enable with the timer at the shutdown delay overrides every mode; in config and hiccup the timer counts from mode entry
    if (state != `BMS_ST_SHDN && tmr_shdn && !line_above_en_i)
      next_state = `BMS_ST_SHDN;
  end

  // state, start filter and shared timer
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= `BMS_ST_SHDN;
      tmr      <= ZERO32;
      filt_cnt <= 16'h0;
    end else if (clk_en_i) begin
      state <= next_state;
      // count starts in the enable band, then the line must stay above enable without a break
      if (state == `BMS_ST_SHDN && (band_ok || (filt_cnt != 16'h0 && enter_ok)))
        filt_cnt <= filt_done ? filt_cnt : filt_cnt + 16'h1;
      else
        filt_cnt <= 16'h0;
      // timer counts config, hiccup off time or shutdown delay
      if (next_state != state)
        tmr <= ZERO32;
      else if (state == `BMS_ST_CFG || state == `BMS_ST_HIC)
        tmr <= tmr + 32'h1;
      else if (state != `BMS_ST_SHDN && !line_above_en_i)
        tmr <= tmr + 32'h1;
      else
        tmr <= ZERO32;
    end
  end

  // ============================================================
  // switching period, duty limit, sync
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pcnt          <= ZERO32;
      sync_d        <= 1'b0;
      switch_en_o   <= 1'b0;
      cycle_start_o <= 1'b0;
    end else if (clk_en_i) begin
      sync_d        <= line_above_lock_i;
      cycle_start_o <= new_cycle;
      pcnt          <= new_cycle ? ZERO32 : pcnt + 32'h1;
      // switch turns on at cycle start, off on loop, limit or forced off
      if (!sw_allow || ss_pulldown_o)
        switch_en_o <= 1'b0;
      else if (new_cycle)
        switch_en_o <= 1'b1;
      else if (forced_off || pwm_off_i || cur_limit_i)
        switch_en_o <= 1'b0;
    end
  end

  // ============================================================
  // hiccup cycle counting
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lim_cnt   <= 7'h0;
      clean_cnt <= 4'h0;
      lim_seen  <= 1'b0;
      hic_trip  <= 1'b0;
    end else if (clk_en_i) begin
      hic_trip <= 1'b0;
      if (!running) begin
        lim_cnt   <= 7'h0;
        clean_cnt <= 4'h0;
        lim_seen  <= 1'b0;
      end else if (new_cycle) begin
        lim_seen <= cur_limit_i;
        if (lim_seen) begin
          clean_cnt <= 4'h0;
          if (lim_cnt == `BMS_HIC_ENTER - 1) begin
            lim_cnt  <= 7'h0;
            hic_trip <= ctrl[`BMS_CTRL_HICCUP];
          end else
            lim_cnt <= lim_cnt + 7'h1;
        end else if (clean_cnt == `BMS_HIC_RESET - 1) begin
          clean_cnt <= 4'h0;
          lim_cnt   <= 7'h0;
        end else
          clean_cnt <= clean_cnt + 4'h1;
      end else if (cur_limit_i)
        lim_seen <= 1'b1;
    end
  end

  // ============================================================
  // per-mode output decode; outputs lag the mode by one clock
  reg         next_regs_en;
  reg         next_hyst_en;
  reg         next_ss_pd;

  always @* begin
    next_regs_en = 1'b0;
    next_hyst_en = 1'b0;
    next_ss_pd   = 1'b1;
    case (state)
      `BMS_ST_SHDN: begin
        // all functions off, the line pin sees only its divider
        next_regs_en = 1'b0;
        next_hyst_en = 1'b0;
        next_ss_pd   = 1'b1;
      end
      `BMS_ST_CFG: begin
        next_regs_en = 1'b0;
        next_hyst_en = line_above_lock_i;
        next_ss_pd   = 1'b1;
      end
      `BMS_ST_STBY: begin
        next_regs_en = 1'b1;
        next_hyst_en = line_above_lock_i;
        next_ss_pd   = 1'b1;
      end
      `BMS_ST_RUN: begin
        next_regs_en = 1'b1;
        next_hyst_en = line_above_lock_i;
        // soft start ramps only with a good supply and no thermal fault
        next_ss_pd   = ~supply_ok_i | line_low | over_temp_i;
      end
      `BMS_ST_HIC: begin
        // regulators stay up so the restart needs no new configuration
        next_regs_en = 1'b1;
        next_hyst_en = line_above_lock_i;
        next_ss_pd   = 1'b1;
      end
      default: begin
        next_regs_en = 1'b0;
        next_hyst_en = 1'b0;
        next_ss_pd   = 1'b1;
      end
    endcase
  end

  // ============================================================
  // analog-facing outputs and fault hysteresis
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hyst_src_en_o   <= 1'b0;
      ss_pulldown_o   <= 1'b1;
      regulators_en_o <= 1'b0;
      power_good_pd_o <= 1'b1;
      overvoltage_o   <= 1'b0;
    end else if (clk_en_i) begin
      hyst_src_en_o   <= next_hyst_en;
      regulators_en_o <= next_regs_en;
      ss_pulldown_o   <= next_ss_pd;
      if (fb_above_ov_i)
        overvoltage_o <= 1'b1;
      else if (!fb_above_ovclr_i)
        overvoltage_o <= 1'b0;
      if (!fb_above_uv_i)
        power_good_pd_o <= 1'b1;
      else if (fb_above_uvclr_i)
        power_good_pd_o <= 1'b0;
    end
  end

  // ============================================================
  // register port and sticky interrupts
  wire [`BMS_EV_W-1:0] events;
  assign events[`BMS_EV_RUN]    = (next_state == `BMS_ST_RUN) & ~running;
  assign events[`BMS_EV_SHDN]   = (next_state == `BMS_ST_SHDN) & (state != `BMS_ST_SHDN);
  assign events[`BMS_EV_HICCUP] = hic_trip;
  assign events[`BMS_EV_OV]     = overvoltage_o & ~ov_d;
  assign events[`BMS_EV_PGBAD]  = power_good_pd_o & ~pg_bad_d;
  assign events[`BMS_EV_TSD]    = over_temp_i & ~tsd_d;
  assign irq_o = |(irq_stat & irq_mask);

  // status readback: live outputs beside the mode code
  wire [31:0] status_word;
  assign status_word[2:0]   = state;
  assign status_word[3]     = 1'b0;
  assign status_word[4]     = regulators_en_o;
  assign status_word[5]     = hyst_src_en_o;
  assign status_word[6]     = power_good_pd_o;
  assign status_word[7]     = overvoltage_o;
  assign status_word[8]     = ss_pulldown_o;
  assign status_word[9]     = switch_en_o;
  assign status_word[31:10] = 22'h0;

  // sticky status bits, one per event
  genvar gi;
  generate
    for (gi = 0; gi < `BMS_EV_W; gi = gi + 1) begin : g_sticky
      wire clr_hit = wr_i & (addr_i == `BMS_REG_IRQ_STAT) & wdata_i[gi];
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          irq_stat[gi] <= 1'b0;
        end else if (clk_en_i) begin
          // a new event wins over a simultaneous write-one-to-clear
          if (events[gi])
            irq_stat[gi] <= 1'b1;
          else if (clr_hit)
            irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl     <= 2'h0;
      irq_mask <= {`BMS_EV_W{1'b0}};
      rdata_o  <= ZERO32;
      ov_d     <= 1'b0;
      pg_bad_d <= 1'b1;
      tsd_d    <= 1'b0;
    end else if (clk_en_i) begin
      ov_d     <= overvoltage_o;
      pg_bad_d <= power_good_pd_o;
      tsd_d    <= over_temp_i;
      if (wr_i && addr_i == `BMS_REG_CTRL)
        ctrl <= wdata_i[1:0];
      if (wr_i && addr_i == `BMS_REG_IRQ_MASK)
        irq_mask <= wdata_i[`BMS_EV_W-1:0];
      rdata_o <= ZERO32;
      if (rd_i) begin
        case (addr_i)
          `BMS_REG_CTRL:     rdata_o <= {30'h0, ctrl};
          `BMS_REG_STATUS:   rdata_o <= status_word;
          `BMS_REG_IRQ_STAT: rdata_o <= {26'h0, irq_stat};
          `BMS_REG_IRQ_MASK: rdata_o <= {26'h0, irq_mask};
          default:           rdata_o <= ZERO32;
        endcase
      end
    end
  end

endmodule // bms_sequencer

// [pkg/bms_regs.vh]
`ifndef BMS_REGS_VH
`define BMS_REGS_VH
// ============================================================
// register indices (byte address = 4 * index)
`define BMS_ADDR_W        4
`define BMS_REG_CTRL      4'h0
`define BMS_REG_STATUS    4'h1
`define BMS_REG_IRQ_STAT  4'h2
`define BMS_REG_IRQ_MASK  4'h3
// ctrl fields
`define BMS_CTRL_HICCUP   0
`define BMS_CTRL_FHIGH    1
// irq / status bit positions
`define BMS_EV_RUN        0
`define BMS_EV_SHDN       1
`define BMS_EV_HICCUP     2
`define BMS_EV_OV         3
`define BMS_EV_PGBAD      4
`define BMS_EV_TSD        5
`define BMS_EV_W          6
// times, ns, as printed
`define BMS_CLK_NS        25
`define BMS_T_FILT_NS     1500
`define BMS_T_CFG_NS      90000
`define BMS_T_SHDN_NS     40000
// duty limits in percent
`define BMS_DMAX_LO_PCT   85
`define BMS_DMAX_HI_PCT   93
`define BMS_PCT_FULL      100
// hiccup counts
`define BMS_HIC_ENTER     64
`define BMS_HIC_RESET     8
// states
`define BMS_ST_SHDN       3'h0
`define BMS_ST_CFG        3'h1
`define BMS_ST_STBY       3'h2
`define BMS_ST_RUN        3'h3
`define BMS_ST_HIC        3'h4
`endif

// [verif/bms_sequencer_props.sv]
`timescale 1ns/10ps
// ============================================================
// port level checks of the sequencer
module bms_sequencer_props #(
  parameter integer PERIOD_CYC = 400,
  parameter integer SHDN_CYC   = 1600
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  input wire line_above_en_i,
  input wire line_above_lock_i,
  input wire fb_above_ov_i,
  input wire fb_above_ovclr_i,
  input wire fb_above_uv_i,
  input wire fb_above_uvclr_i,
  input wire over_temp_i,
  input wire hyst_src_en_o,
  input wire ss_pulldown_o,
  input wire switch_en_o,
  input wire regulators_en_o,
  input wire power_good_pd_o,
  input wire overvoltage_o,
  input wire cycle_start_o
);
  localparam int DMAX_ON  = PERIOD_CYC * 93 / 100; // widest duty setting bounds both
  localparam int SHDN_LIM = SHDN_CYC + 3;          // shutdown delay plus state and output lag
  int on_cnt;
  int low_cnt;
  default clocking @(posedge clk_i); endclocking
  // a frozen block holds every output, so checks pause with the enable
  default disable iff (!reset_n_i || !clk_en_i);
  // run lengths: switch on time and line below enable
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      on_cnt  <= 0;
      low_cnt <= 0;
    end else if (clk_en_i) begin
      on_cnt  <= switch_en_o ? on_cnt + 1 : 0;
      low_cnt <= line_above_en_i ? 0 : low_cnt + 1;
    end
  end
  duty_cap_a: assert property (on_cnt <= DMAX_ON) else $error("switch on past duty limit");
  shdn_delay_a: assert property (low_cnt > SHDN_LIM |-> !regulators_en_o && !switch_en_o)
    else $error("no shutdown after line low");
  idle_no_sw_a: assert property (!regulators_en_o |-> !switch_en_o) else $error("switching while idle");
  thermal_stop_a: assert property (over_temp_i [*3] |-> !switch_en_o && ss_pulldown_o)
    else $error("switching during over temperature");
  hyst_on_a: assert property ((regulators_en_o && line_above_lock_i) [*3] |-> hyst_src_en_o)
    else $error("hysteresis source not on");
  hyst_off_a: assert property ((!line_above_lock_i) [*3] |-> !hyst_src_en_o)
    else $error("hysteresis source not off");
  ov_set_a: assert property ((fb_above_ov_i && regulators_en_o) [*3] |-> overvoltage_o)
    else $error("overvoltage flag not set");
  ov_hold_a: assert property ((fb_above_ovclr_i && regulators_en_o) [*3] ##0 overvoltage_o |=> overvoltage_o)
    else $error("overvoltage flag dropped early");
  pg_set_a: assert property ((!fb_above_uv_i && regulators_en_o) [*3] |-> power_good_pd_o)
    else $error("power good pull down not on");
  pg_hold_a: assert property ((!fb_above_uvclr_i && regulators_en_o) [*3] ##0 power_good_pd_o |=> power_good_pd_o)
    else $error("power good released early");
  sw_on_start_a: assert property ($rose(switch_en_o) |-> cycle_start_o)
    else $error("switch on outside cycle start");
  cover property ($rose(overvoltage_o));
  cover property ($rose(hyst_src_en_o));
  cover property ($fell(regulators_en_o));
endmodule // bms_sequencer_props

// [verif/bms_analog_model.sv]
`timescale 1ns/10ps
// ============================================================
// analog front end: comparators and current sense
module bms_analog_model (
  input  wire [1:0] line_lvl_i,   // 0 below enable, 1 enable band, 2 above lockout
  input  wire [7:0] fb_pct_i,     // feedback in percent of reference
  input  wire       overload_i,
  input  wire       switch_en_i,
  output wire       line_above_en_o,
  output wire       line_above_lock_o,
  output wire       fb_above_ov_o,
  output wire       fb_above_ovclr_o,
  output wire       fb_above_uv_o,
  output wire       fb_above_uvclr_o,
  output wire       cur_limit_o
);
  // separate rise and fall levels; the design must build the hysteresis
  assign line_above_en_o   = (line_lvl_i != 2'h0);
  assign line_above_lock_o = (line_lvl_i == 2'h2);
  assign fb_above_ov_o     = (fb_pct_i > 8'h6e);
  assign fb_above_ovclr_o  = (fb_pct_i > 8'h69);
  assign fb_above_uv_o     = (fb_pct_i > 8'h5a);
  assign fb_above_uvclr_o  = (fb_pct_i > 8'h5f);
  // limit can only trip while the switch conducts
  assign cur_limit_o       = overload_i & switch_en_i;
endmodule // bms_analog_model

// [verif/bms_sequencer_tb.sv]
`timescale 1ns/10ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin errors++; $display("Error at %0t: got %h exp %h", $time, g, x); end end
// ============================================================
// sequencer bench
module bms_sequencer_tb;
  localparam integer PER = 20;
  localparam integer SHD = 20;
  reg         clk_i = 1'b0, reset_n_i = 1'b0, supply_ok = 1'b1, over_temp = 1'b0, overload = 1'b0;
  reg         wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, clk_en = 1'b1;
  reg  [1:0]  line_lvl = 2'h0;
  reg  [7:0]  fb_pct = 8'h64;
  reg  [3:0]  addr_i = 4'h0;
  reg  [31:0] wdata_i = 32'h0, rv;
  wire [31:0] rdata_o;
  wire        irq_o, l_en, l_lock, f_ov, f_ovc, f_uv, f_uvc, c_lim, sw_en;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [7:0] fbt[7] = '{8'h70, 8'h6b, 8'h68, 8'h5c, 8'h58, 8'h5d, 8'h60};
  logic [7:0] fbx[7] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00};
  int errors = 0, n_tests = 0, cyc = 0, k;
  bms_analog_model afe (.line_lvl_i(line_lvl), .fb_pct_i(fb_pct), .overload_i(overload), .switch_en_i(sw_en),
    .line_above_en_o(l_en), .line_above_lock_o(l_lock), .fb_above_ov_o(f_ov), .fb_above_ovclr_o(f_ovc),
    .fb_above_uv_o(f_uv), .fb_above_uvclr_o(f_uvc), .cur_limit_o(c_lim));
  // long counts shortened so the run stays brief
  bms_sequencer #(.PERIOD_CYC(PER), .HIC_OFF_CYC(50), .CFG_CYC(20), .SHDN_CYC(SHD)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .bias_ok_i(1'b1), .line_above_en_i(l_en),
    .line_above_lock_i(l_lock), .supply_ok_i(supply_ok), .fb_above_ov_i(f_ov), .fb_above_ovclr_i(f_ovc),
    .fb_above_uv_i(f_uv), .fb_above_uvclr_i(f_uvc), .cur_limit_i(c_lim), .pwm_off_i(1'b0),
    .over_temp_i(over_temp), .sync_mode_i(1'b0), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .hyst_src_en_o(), .ss_pulldown_o(), .switch_en_o(sw_en),
    .regulators_en_o(), .power_good_pd_o(), .overvoltage_o(), .cycle_start_o());
  always #12.5 clk_i = ~clk_i;
  task final_report;
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // extra edge at the end so the strobe is never set twice in one step
  task wr(input [3:0] a, input [31:0] d);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input [3:0] a, input [31:0] m, input [31:0] x);
    exp_q.push_back({m, x});
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    rv = rdata_o;
  endtask
  task poll(input [2:0] s);
    k = 0;
    do begin rd(4'h1, 32'h0, 32'h0); k++; end while (rv[2:0] !== s && k < 400);
  endtask
  // read data stand only in the cycle after the strobe; also the hang guard
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    cyc++;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(rdata_o & e[63:32], e[31:0])
    end
    if (cyc == 12000) begin errors++; final_report; end
  end
  initial begin
    k = $urandom(32'hee46);
    tick(6);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(4'h1, 32'h3b7, 32'h100);
    foreach (fbt[i]) rd(i == 1 ? 4'h9 : 4'(i), 32'hffffffff, 32'h0);
    line_lvl <= 2'h1;
    tick(1 + $urandom % 50);
    line_lvl <= 2'h0;
    tick(2);
    rd(4'h1, 32'h7, 32'h0);
    line_lvl <= 2'h1;
    tick(68);
    rd(4'h1, 32'h7, 32'h1);
    tick(20);
    rd(4'h1, 32'h317, 32'h112);
    wr(4'h3, 32'h3f);
    supply_ok <= 1'b0; line_lvl <= 2'h2;
    tick(4);
    rd(4'h1, 32'h337, 32'h133);
    `CHK(irq_o, 1'b1)
    supply_ok <= 1'b1;
    tick(3);
    rd(4'h1, 32'h100, 32'h0);
    rd(4'h2, 32'h1, 32'h1);
    wr(4'h3, 32'h0);
    `CHK(irq_o, 1'b0)
    wr(4'h2, 32'h3f); wr(4'h3, 32'h3f);
    `CHK(irq_o, 1'b0)
    wr(4'h0, 32'h2); tick(6 * PER); wr(4'h0, 32'h1);
    overload <= 1'b1; tick(60 * PER);
    overload <= 1'b0; tick(10 * PER);
    overload <= 1'b1; tick(60 * PER);
    rd(4'h1, 32'h7, 32'h3);
    poll(3'h4);
    rd(4'h1, 32'h307, 32'h104);
    overload <= 1'b0;
    poll(3'h3);
    `CHK(rv[2:0], 3'h3)
    foreach (fbt[i]) begin fb_pct <= fbt[i]; tick(4); rd(4'h1, 32'hc0, {24'h0, fbx[i]}); end
    over_temp <= 1'b1; tick(4);
    rd(4'h1, 32'h300, 32'h100);
    over_temp <= 1'b0; tick(4);
    rd(4'h1, 32'h107, 32'h3);
    rd(4'h2, 32'h20, 32'h20);
    clk_en <= 1'b0; line_lvl <= 2'h1; tick(4);
    clk_en <= 1'b1; line_lvl <= 2'h2; tick(2);
    rd(4'h1, 32'h7, 32'h3);
    line_lvl <= 2'h1; tick(4);
    rd(4'h1, 32'h307, 32'h102);
    line_lvl <= 2'h0; tick(1 + $urandom % (SHD - 4));
    line_lvl <= 2'h1; tick(2);
    rd(4'h1, 32'h7, 32'h2);
    line_lvl <= 2'h0; tick(SHD + 4);
    rd(4'h1, 32'h17, 32'h0);
    rd(4'h2, 32'h2, 32'h2);
    final_report;
  end
endmodule // bms_sequencer_tb
bind bms_sequencer bms_sequencer_props #(.PERIOD_CYC(PERIOD_CYC), .SHDN_CYC(SHDN_CYC)) props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .cycle_start_o(cycle_start_o),
  .line_above_en_i(line_above_en_i), .line_above_lock_i(line_above_lock_i),
  .fb_above_ov_i(fb_above_ov_i), .fb_above_ovclr_i(fb_above_ovclr_i), .fb_above_uv_i(fb_above_uv_i),
  .fb_above_uvclr_i(fb_above_uvclr_i), .over_temp_i(over_temp_i), .hyst_src_en_o(hyst_src_en_o),
  .ss_pulldown_o(ss_pulldown_o), .switch_en_o(switch_en_o), .regulators_en_o(regulators_en_o),
  .power_good_pd_o(power_good_pd_o), .overvoltage_o(overvoltage_o));
